/* include/tchd_pkg.sv */
// package for the tape coupler host datapath: constants and carried structs
package tchd_pkg;
  localparam int unsigned TCHD_CLK_HZ = 50000000;
  localparam int unsigned TCHD_SYS_HZ = 6000000;
  localparam int unsigned TCHD_XTAL_HZ = 12000000;
  localparam int unsigned TCHD_SYS_PERIOD_NS = 167;
  // crystal tick count, then halved for the symmetric system clock
  localparam int unsigned TCHD_XTAL_DIV = TCHD_CLK_HZ / TCHD_XTAL_HZ;
  localparam logic [3:0] TCHD_XTAL_LAST = 4'(TCHD_XTAL_DIV - 1);
  localparam int unsigned TCHD_DATA_W = 16;
  localparam int unsigned TCHD_ADDR_W = 18;
  localparam int unsigned TCHD_CTRL_W = 22;
  localparam int unsigned TCHD_BYTE_W = 8;
  localparam int unsigned TCHD_RAM_DEPTH = 256;
  localparam int unsigned TCHD_FIFO_DEPTH = 1024;
  localparam int unsigned TCHD_DRIVES = 4;
  localparam int unsigned TCHD_PKT_WORDS = 4;
  localparam logic [7:0] TCHD_STAT_BASE = 8'hF0;
  // control line positions within the 22-line group
  localparam int unsigned TCHD_C_MSYN = 0;
  localparam int unsigned TCHD_C_SSYN = 1;
  localparam int unsigned TCHD_C_C0 = 2;
  localparam int unsigned TCHD_C_C1 = 3;
  localparam int unsigned TCHD_C_NPR = 4;
  localparam int unsigned TCHD_C_NPG = 5;
  localparam int unsigned TCHD_C_SACK = 6;
  localparam int unsigned TCHD_C_BBSY = 7;
  localparam int unsigned TCHD_C_INIT = 8;

  typedef enum logic [2:0] {
    TCHD_IDLE = 3'b000,
    TCHD_REQ = 3'b001,
    TCHD_ADDR = 3'b010,
    TCHD_SYNC = 3'b011,
    TCHD_WAIT = 3'b100,
    TCHD_END = 3'b101
  } tchd_dma_e;

  typedef struct packed {
    logic [TCHD_DATA_W-1:0] data;
    logic [TCHD_ADDR_W-1:0] addr;
    logic [TCHD_CTRL_W-1:0] ctrl;
  } tchd_bus_s;

  typedef struct packed {
    logic [TCHD_DATA_W-1:0] data;
    logic [TCHD_ADDR_W-1:0] addr;
    logic [TCHD_CTRL_W-1:0] ctrl;
  } tchd_bus_oe_s;

  typedef struct packed {
    logic [TCHD_BYTE_W-1:0] data;
    logic [1:0] drive;
    logic valid;
  } tchd_byte_s;
endpackage

/* hw/tchd_top.sv */
// tape coupler host datapath: bus slave, dma master, packet ram and drive fifo
`timescale 1ns/1ps
// How it works
// - drive output register paced by 6 MHz system enable, in-phase extra clock out.
// - host port has 16 data and 18 address lines, each three-signal.
// - 22 control lines driven by host or device request and sync transfers.
// - each transfer starts with the master driving an address, with write data alongside it, then master sync.
// - packet address writes and status word reads are answered only as bus slave.
// - packet fetch and status writes use npr mastership, reading or writing memory.
// - dma handshake timing is separate logic from the sequencer.
// - host gives packet address; device fetches packet words and keeps the low byte of each in the packet ram.
// - rewinds on idle drives proceed while another drive transfers data.
// - 256-byte ram buffers packets only, four words of buffering.
// - 1024 by 8 fifo plus two drive-side byte registers.
// - up to four tape drives are served.
// - operand bus into alu, result bus out, both 8 bits.
// - sequencer paces bytes to drive in the order they leave the fifo.
// - error and status bits are packed into bytes and written to memory.
// - system rate is the 12 MHz time base divided by two.
module tchd_top
  import tchd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tchd_pkg::tchd_bus_s bus_in,
  output tchd_pkg::tchd_bus_s bus_out,
  output tchd_pkg::tchd_bus_oe_s bus_oe,
  output logic extra_clock_n,
  output logic sys_clk_n,
  output tchd_pkg::tchd_byte_s drv_wr,
  input wire logic drv_wr_ready,
  input wire tchd_pkg::tchd_byte_s drv_rd,
  input wire logic [3:0] drv_rewinding,
  input wire logic [7:0] drv_status,
  output logic [3:0] drv_rewind_cmd,
  output logic [7:0] host_status_word,
  output logic busy
);
  import tchd_pkg::*;

  typedef struct packed {
    logic [3:0] xtal_cnt;
    logic sys_ph;
    tchd_dma_e dma;
    logic [TCHD_ADDR_W-1:0] dma_addr;
    logic dma_write;
    logic [TCHD_DATA_W-1:0] dma_data;
    logic [1:0] pkt_idx;
    logic fetching;
    logic pkt_done;
    logic [1:0] stat_idx;
    logic stat_pend;
    logic [TCHD_ADDR_W-1:0] pkt_base;
    logic slave_ssyn;
    logic [TCHD_DATA_W-1:0] slave_data;
    logic [9:0] fifo_wp;
    logic [9:0] fifo_rp;
    logic [10:0] fifo_cnt;
    logic [7:0] hold_a;
    logic hold_a_v;
    tchd_byte_s out_byte;
    logic [7:0] in_byte;
    logic [1:0] sel_drive;
    logic [3:0] rewind;
    logic [7:0] status_byte;
    logic byte_hi;
  } tchd_state_s;

  tchd_state_s st_r, st_nxt;
  logic [7:0] pkt_ram [TCHD_RAM_DEPTH];
  logic [7:0] fifo_mem [TCHD_FIFO_DEPTH];
  logic sys_en;
  logic [7:0] d_bus;
  logic [7:0] y_bus;
  logic ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;
  logic fifo_push;
  logic fifo_pop;
  logic dma_cycle_begin_n;
  logic dma_cycle_halt_n;
  logic slave_hit;
  logic init_seen;

  // 12 MHz tick every TCHD_XTAL_DIV cycles, system phase toggles on each
  assign sys_en = (st_r.xtal_cnt == TCHD_XTAL_LAST) && st_r.sys_ph;
  assign slave_hit = bus_in.ctrl[TCHD_C_MSYN] && (bus_in.addr[TCHD_ADDR_W-1:3] == '1);
  assign init_seen = bus_in.ctrl[TCHD_C_INIT];

  // operand bus feeds the alu, result bus returns; the alu here is a pass/merge
  assign d_bus = drv_rd.valid ? drv_rd.data : st_r.slave_data[7:0];
  assign y_bus = d_bus ^ 8'h00;

  always_comb begin
    st_nxt = st_r;
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    dma_cycle_begin_n = 1'b1;
    dma_cycle_halt_n = 1'b1;
    st_nxt.xtal_cnt = (st_r.xtal_cnt == TCHD_XTAL_LAST) ? 4'h0 : st_r.xtal_cnt + 4'h1;
    if (st_r.xtal_cnt == TCHD_XTAL_LAST) begin
      st_nxt.sys_ph = ~st_r.sys_ph;
    end
    // slave side: packet address writes and status word reads only
    st_nxt.slave_ssyn = 1'b0;
    if (slave_hit && st_r.dma == TCHD_IDLE && !st_r.slave_ssyn) begin
      st_nxt.slave_ssyn = 1'b1;
      if (bus_in.ctrl[TCHD_C_C1]) begin
        st_nxt.pkt_base = {2'b00, bus_in.data};
        st_nxt.fetching = 1'b1;
        st_nxt.pkt_idx = 2'd0;
      end else begin
        st_nxt.slave_data = {8'h00, host_status_word};
      end
    end
    // rewinds run per drive, except that the rewind of the selected drive (sel_drive) is masked off
    st_nxt.rewind = drv_rewinding & ~(4'b0001 << st_r.sel_drive);
    // drive side input: hardware byte register into fifo
    if (drv_rd.valid && st_r.fifo_cnt < 11'(TCHD_FIFO_DEPTH)) begin
      fifo_push = 1'b1;
      st_nxt.sel_drive = drv_rd.drive;
      st_nxt.in_byte = drv_rd.data;
    end
    // output register paced on system enable
    if (st_r.out_byte.valid && drv_wr_ready) begin
      st_nxt.out_byte.valid = 1'b0;
    end
    if (sys_en && (!st_r.out_byte.valid || drv_wr_ready) && st_r.hold_a_v) begin
      st_nxt.out_byte = '{data: st_r.hold_a, drive: st_r.sel_drive, valid: 1'b1};
      st_nxt.hold_a_v = 1'b0;
    end
    if (st_r.fifo_cnt != 11'd0 && !st_nxt.hold_a_v) begin
      fifo_pop = 1'b1;
      st_nxt.hold_a = fifo_mem[st_r.fifo_rp];
      st_nxt.hold_a_v = 1'b1;
    end
    if (fifo_push) begin
      st_nxt.fifo_wp = st_r.fifo_wp + 10'd1;
    end
    if (fifo_pop) begin
      st_nxt.fifo_rp = st_r.fifo_rp + 10'd1;
    end
    st_nxt.fifo_cnt = st_r.fifo_cnt + {10'd0, fifo_push} - {10'd0, fifo_pop};
    // status packing into a byte
    st_nxt.status_byte = {drv_status[7:4], |drv_rewinding, st_r.fifo_cnt == 11'd0,
      st_r.fifo_cnt >= 11'(TCHD_FIFO_DEPTH), st_r.pkt_done};
    // dma engine: independent handshake logic
    case (st_r.dma)
      TCHD_IDLE: begin
        if (st_r.fetching || st_r.stat_pend) begin
          st_nxt.dma = TCHD_REQ;
        end
      end
      TCHD_REQ: begin
        if (bus_in.ctrl[TCHD_C_NPG]) begin
          st_nxt.dma = TCHD_ADDR;
          st_nxt.dma_write = !st_r.fetching;
          st_nxt.dma_addr = st_r.fetching ?
            st_r.pkt_base + {15'd0, st_r.pkt_idx, 1'b0} :
            st_r.pkt_base + {15'd0, st_r.stat_idx, 1'b0};
          st_nxt.dma_data = {st_r.status_byte, y_bus};
        end
      end
      TCHD_ADDR: begin
        if (!bus_in.ctrl[TCHD_C_BBSY]) begin
          dma_cycle_begin_n = 1'b0;
          st_nxt.dma = TCHD_SYNC;
        end
      end
      TCHD_SYNC: st_nxt.dma = TCHD_WAIT;
      TCHD_WAIT: begin
        if (bus_in.ctrl[TCHD_C_SSYN]) begin
          dma_cycle_halt_n = 1'b0;
          st_nxt.dma = TCHD_END;
          if (st_r.fetching) begin
            ram_we = 1'b1; // low byte of each packet word lands in ram
            ram_wa = {5'd0, st_r.pkt_idx, st_r.byte_hi};
            ram_wd = bus_in.data[7:0];
            st_nxt.pkt_idx = st_r.pkt_idx + 2'd1;
            if (st_r.pkt_idx == 2'(TCHD_PKT_WORDS - 1)) begin
              st_nxt.fetching = 1'b0;
              st_nxt.pkt_done = 1'b1;
              st_nxt.stat_pend = 1'b1;
            end
          end else begin
            st_nxt.stat_idx = st_r.stat_idx + 2'd1;
            st_nxt.stat_pend = 1'b0;
          end
        end
      end
      TCHD_END: begin
        if (!bus_in.ctrl[TCHD_C_SSYN]) begin
          st_nxt.dma = TCHD_IDLE;
        end
      end
      default: st_nxt.dma = TCHD_IDLE;
    endcase
    if (init_seen) begin
      st_nxt.dma = TCHD_IDLE;
      st_nxt.fetching = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      pkt_ram[ram_wa] <= ram_wd;
    end
    if (fifo_push) begin
      fifo_mem[st_r.fifo_wp] <= drv_rd.data;
    end
  end

  // bus drive: address and write data together, then master sync; lines released when not master or slave
  always_comb begin
    bus_out = '0;
    bus_oe = '0;
    if (st_r.dma inside {TCHD_ADDR, TCHD_SYNC, TCHD_WAIT}) begin
      bus_out.addr = st_r.dma_addr;
      bus_oe.addr = '1;
      // claim bus busy only after the free check, else the address state waits on itself
      bus_out.ctrl[TCHD_C_BBSY] = st_r.dma != TCHD_ADDR;
      bus_oe.ctrl[TCHD_C_BBSY] = st_r.dma != TCHD_ADDR;
      bus_out.ctrl[TCHD_C_C1] = st_r.dma_write;
      bus_oe.ctrl[TCHD_C_C1] = 1'b1;
      bus_out.data = st_r.dma_data;
      bus_oe.data = {TCHD_DATA_W{st_r.dma_write}};
      bus_out.ctrl[TCHD_C_MSYN] = st_r.dma != TCHD_ADDR;
      bus_oe.ctrl[TCHD_C_MSYN] = 1'b1;
    end
    if (st_r.dma == TCHD_REQ) begin
      bus_out.ctrl[TCHD_C_NPR] = 1'b1;
      bus_oe.ctrl[TCHD_C_NPR] = 1'b1;
    end
    if (st_r.slave_ssyn) begin
      bus_out.ctrl[TCHD_C_SSYN] = 1'b1;
      bus_oe.ctrl[TCHD_C_SSYN] = 1'b1;
      bus_out.data = st_r.slave_data;
      bus_oe.data = '1;
    end
  end

  assign extra_clock_n = ~st_r.sys_ph;
  assign sys_clk_n = ~st_r.sys_ph;
  assign drv_wr = st_r.out_byte;
  assign drv_rewind_cmd = st_r.rewind;
  assign host_status_word = st_r.status_byte;
  assign busy = (st_r.dma != TCHD_IDLE) || st_r.fetching;
endmodule // tchd_top

/* tb/tchd_chk_assertions.sv */
// concurrent checks on the tape coupler host datapath ports
`timescale 1ns/1ps
module tchd_chk
  import tchd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tchd_pkg::tchd_bus_s bus_in,
  input wire tchd_pkg::tchd_bus_s bus_out,
  input wire tchd_pkg::tchd_bus_oe_s bus_oe,
  input wire logic extra_clock_n,
  input wire logic sys_clk_n,
  input wire tchd_pkg::tchd_byte_s drv_wr,
  input wire logic drv_wr_ready,
  input wire logic busy
);
  logic sl;
  logic so;
  assign sl = bus_in.ctrl[TCHD_C_MSYN] && (&bus_in.addr[17:3]);
  assign so = bus_out.ctrl[TCHD_C_SSYN];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // the reset check must stay live while reset is high
  chk_reset_idle: assert property (disable iff (1'b0) rst |=> bus_oe == '0 && !busy)
    else $error("outputs not idle after reset");
  chk_clock_phase: assert property (extra_clock_n == sys_clk_n)
    else $error("extra clock out of phase");
  chk_slave_answer: assert property (sl && !busy && !so |=> so && bus_oe.ctrl[TCHD_C_SSYN])
    else $error("slave sync missing");
  chk_ssyn_pulse: assert property ($rose(so) |=> !so)
    else $error("slave sync longer than one cycle");
  chk_fetch_start: assert property (sl && bus_in.ctrl[TCHD_C_C1] && !busy && !so
    |=> ##1 bus_out.ctrl[TCHD_C_NPR])
    else $error("request not raised after packet address");
  chk_addr_first: assert property ($rose(bus_out.ctrl[TCHD_C_MSYN])
    |-> (&bus_oe.addr) && (&$past(bus_oe.addr)))
    else $error("master sync before address");
  chk_msyn_end: assert property (bus_out.ctrl[TCHD_C_MSYN] && bus_in.ctrl[TCHD_C_SSYN]
    |-> ##[1:3] !bus_out.ctrl[TCHD_C_MSYN])
    else $error("master sync held after answer");
  chk_init_abort: assert property (bus_in.ctrl[TCHD_C_INIT]
    |-> ##[1:3] (!busy && !bus_out.ctrl[TCHD_C_NPR]))
    else $error("init did not abort transfer");
  chk_byte_hold: assert property (drv_wr.valid && !drv_wr_ready |=> drv_wr.valid && $stable(drv_wr))
    else $error("drive byte dropped before accept");
endmodule // tchd_chk
bind tchd_top tchd_chk u_chk (.ref_clk(ref_clk), .rst(rst), .bus_in(bus_in), .bus_out(bus_out),
  .bus_oe(bus_oe), .extra_clock_n(extra_clock_n), .sys_clk_n(sys_clk_n), .drv_wr(drv_wr),
  .drv_wr_ready(drv_wr_ready), .busy(busy));

/* tb/tchd_hmem.sv */
// host memory model answering the device as bus master
`timescale 1ns/1ps
module tchd_hmem
  import tchd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire tchd_pkg::tchd_bus_s dev,
  input wire logic slow,
  output tchd_pkg::tchd_bus_s hst,
  output logic [7:0] n_rd,
  output logic [7:0] n_wr,
  output logic [15:0] wr_data
);
  logic [1:0] dly;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hst <= '0;
      n_rd <= '0;
      n_wr <= '0;
      wr_data <= '0;
      dly <= '0;
    end else begin
      hst.ctrl[TCHD_C_NPG] <= dev.ctrl[TCHD_C_NPR];
      if (dev.ctrl[TCHD_C_MSYN] && !hst.ctrl[TCHD_C_SSYN]) begin
        dly <= dly + 2'h1;
        // slow mode stretches the answer to test the handshake wait
        if (dly >= {slow, 1'b0}) begin
          hst.ctrl[TCHD_C_SSYN] <= 1'b1;
          if (dev.ctrl[TCHD_C_C1]) begin
            n_wr <= n_wr + 8'h01;
            wr_data <= dev.data;
          end else begin
            n_rd <= n_rd + 8'h01;
            hst.data <= dev.addr[15:0] ^ 16'h5A3C;
          end
        end
      end else if (!dev.ctrl[TCHD_C_MSYN]) begin
        // released lines fall to the deasserted level
        hst.ctrl[TCHD_C_SSYN] <= 1'b0;
        hst.data <= '0;
        dly <= '0;
      end
    end
  end
endmodule // tchd_hmem

/* tb/tb.sv */
// testbench for the tape coupler host datapath
`timescale 1ns/1ps
module tb;
  import tchd_pkg::*;
  logic ref_clk, rst, slow, rdy, extra_clock_n, sys_clk_n, busy;
  tchd_bus_s bus_in, bus_out, dev, hst, td;
  tchd_bus_oe_s bus_oe;
  tchd_byte_s drv_wr, drv_rd;
  logic [3:0] rew, rcmd;
  logic [7:0] dst, hsw, n_rd, n_wr;
  logic [15:0] wr_d;
  int num_errors, tests_run;
  assign dev = bus_out & tchd_bus_s'(bus_oe);
  assign bus_in = dev | hst | td;
  tchd_top dut (.ref_clk(ref_clk), .rst(rst), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .extra_clock_n(extra_clock_n), .sys_clk_n(sys_clk_n), .drv_wr(drv_wr),
    .drv_wr_ready(rdy), .drv_rd(drv_rd), .drv_rewinding(rew), .drv_status(dst),
    .drv_rewind_cmd(rcmd), .host_status_word(hsw), .busy(busy));
  tchd_hmem u_mem (.ref_clk(ref_clk), .rst(rst), .dev(dev), .slow(slow), .hst(hst),
    .n_rd(n_rd), .n_wr(n_wr), .wr_data(wr_d));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) rdy <= #1 ~rdy;
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // host slave access: hold until slave sync is sampled, then release
  task automatic slv(input logic wr, input logic [17:0] a, input logic [15:0] d,
                     output logic ok, output logic [15:0] q);
    int i;
    td.addr = a;
    td.data = d;
    td.ctrl[TCHD_C_C1] = wr;
    td.ctrl[TCHD_C_MSYN] = 1'b1;
    for (i = 0; i < 8 && bus_in.ctrl[TCHD_C_SSYN] !== 1'b1; i++) tk(1);
    ok = (i < 8);
    q = bus_in.data;
    tk(1);
    td = '0;
  endtask
  task automatic t_clock;
    int i, h;
    logic v;
    v = sys_clk_n;
    // align to a phase change first, then count clocks until the next one
    for (i = 0; i < 50 && sys_clk_n === v; i++) tk(1);
    v = sys_clk_n;
    h = 0;
    while (h < 50 && sys_clk_n === v) begin
      tk(1);
      h++;
    end
    cmp("half period", TCHD_XTAL_DIV, h);
    cmp("extra clock", sys_clk_n, extra_clock_n);
    $display("test clock done");
  endtask
  task automatic t_pkt(input logic s);
    int i;
    logic ok;
    logic [15:0] q;
    logic [7:0] r0, w0;
    slow = s;
    r0 = n_rd;
    w0 = n_wr;
    slv(1'b1, 18'h3FFF8, 16'h1000, ok, q);
    cmp("pkt sync", 1, ok);
    // busy dips for a cycle between the fetch and the status write
    for (i = 0; i < 2000 && (busy !== 1'b0 || n_wr == w0); i++) tk(1);
    if (i == 2000) begin
      num_errors++;
      conclude;
    end
    cmp("reads", TCHD_PKT_WORDS, n_rd - r0);
    cmp("writes", 1, n_wr - w0);
    cmp("status byte", 8'h3D, wr_d[15:8]);
    $display("test packet slow=%0b done", s);
  endtask
  task automatic t_drive;
    int i, n;
    tchd_byte_s got [2];
    drv_rd = '{data: 8'hA5, drive: 2'd2, valid: 1'b1};
    tk(1);
    drv_rd.data = 8'h5A;
    tk(1);
    drv_rd = '0;
    n = 0;
    // the falling edge sees ready settled, so a hit here is taken at the next rise
    for (i = 0; i < 100 && n < 2; i++) begin
      @(negedge ref_clk);
      if (drv_wr.valid === 1'b1 && rdy === 1'b1) begin
        got[n] = drv_wr;
        n++;
      end
    end
    cmp("bytes out", 2, n);
    cmp("byte 0", {8'hA5, 2'd2, 1'b1}, got[0]);
    cmp("byte 1", {8'h5A, 2'd2, 1'b1}, got[1]);
    cmp("rewind busy", 4'h1, rcmd);
    $display("test drive done");
  endtask
  initial begin
    logic ok;
    logic [15:0] q;
    rst = 1'b1;
    td = '0;
    slow = 1'b0;
    rdy = 1'b0;
    drv_rd = '0;
    rew = 4'h5;
    dst = 8'h3C;
    num_errors = 0;
    tests_run = 0;
    tk(10);
    cmp("oe idle", 0, bus_oe.ctrl);
    cmp("busy idle", 0, busy);
    cmp("clk idle", 1, extra_clock_n);
    rst = 1'b0;
    $display("test reset done");
    t_clock;
    slv(1'b0, 18'h3FFF8, 16'h0000, ok, q);
    tk(4);
    cmp("status sync", 1, ok);
    cmp("status read", 16'h003C, q);
    cmp("status word", 8'h3C, hsw);
    cmp("rewind idle", 4'h4, rcmd);
    cmp("no request", 0, bus_out.ctrl[TCHD_C_NPR]);
    cmp("no fetch", 0, n_rd);
    $display("test status done");
    t_pkt(1'b0);
    t_pkt(1'b1);
    slv(1'b1, 18'h3FFF8, 16'h2000, ok, q);
    tk(3);
    td.ctrl[TCHD_C_INIT] = 1'b1;
    tk(1);
    td.ctrl[TCHD_C_INIT] = 1'b0;
    tk(3);
    cmp("abort busy", 0, busy);
    cmp("abort msyn", 0, bus_out.ctrl[TCHD_C_MSYN]);
    $display("test init done");
    t_pkt(1'b0);
    t_drive;
    conclude;
  end
endmodule // tb
